// ===== logic/sdbg_pkg.sv
/*
  Shared constants for the single-pin debug controller: command bytes,
  control register fields, serial timing, CRC setup and FSM states.
  Assumes the system clock runs at CLK_HZ.
*/
`default_nettype none
package sdbg_pkg;
    // Command bytes
    localparam logic [7:0] CMD_CRC = 8'h0e;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;
    // Control register fields and values
    localparam int CTRL_MODE_BIT = 7;
    localparam int CTRL_BRK_BIT = 6;
    localparam int CTRL_RST_BIT = 0;
    localparam logic [7:0] CTRL_RST_STOP = 8'h81;
    localparam logic [7:0] CTRL_RST_GO = 8'h41;
    localparam logic [7:0] CTRL_RUN = 8'h40;
    localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
    // Device reset request length in cycles
    localparam logic [2:0] RST_PULSE_CYC = 3'h4;
    // Serial timing
    localparam int CLK_HZ = 250000000;
    localparam int BAUD_RATE = 115200;
    localparam int BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam logic [3:0] STOP_BIT_IDX = 4'h9;
    // CRC
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    // Longest instruction in bytes
    localparam logic [2:0] MAX_INSTR = 3'h5;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_OPCODE = 8'h02,
        ST_INSTR = 8'h04,
        ST_DISCARD = 8'h08,
        ST_CRC = 8'h10,
        ST_SENDH = 8'h20,
        ST_SENDL = 8'h40,
        ST_RUN = 8'h80
    } sdbg_state_t;
endpackage
`default_nettype wire

// ===== logic/sdbg_byte_if.sv
/*
  Byte stream carrier with valid/ready between the controller's modules.
  Assumes both ends share clk_sys.
*/
`default_nettype none
interface sdbg_byte_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/sdbg_fifo2.sv
/*
  Small valid/ready buffer, two entries by default.
  Assumes DEPTH is a power of two.
*/
`default_nettype none
module sdbg_fifo2 #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    sdbg_byte_if.snk inIf,
    sdbg_byte_if.src outIf
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic push;
    logic pop;

    assign inIf.ready = cnt_ff != FULL;
    assign outIf.valid = cnt_ff != '0;
    assign outIf.data = mem_ff[rd_ff];
    assign push = inIf.valid && inIf.ready;
    assign pop = outIf.valid && outIf.ready;

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ff] <= inIf.data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== logic/sdbg_serial.sv
/*
  Half-duplex byte transceiver on the single debug pin: start bit,
  eight data bits LSB first, one stop bit, idle high.
  Assumes pinIn is synchronous to clk_sys and the wire is pulled high.
*/
`default_nettype none
module sdbg_serial #(
    parameter int BIT_CYC = sdbg_pkg::BIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    sdbg_byte_if.src rx,
    sdbg_byte_if.snk tx
);
    localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
    logic rxBusy_ff;
    logic [15:0] rxCnt_ff;
    logic [3:0] rxBit_ff;
    logic [7:0] rxSh_ff;
    logic rxValid_ff;
    logic [7:0] rxData_ff;
    logic txBusy_ff;
    logic [15:0] txCnt_ff;
    logic [3:0] txBit_ff;
    logic [9:0] txSh_ff;

    assign tx.ready = !txBusy_ff && !rxBusy_ff;
    assign pinOe = txBusy_ff;
    assign pinOut = txSh_ff[0];
    assign rx.valid = rxValid_ff;
    assign rx.data = rxData_ff;

    // Receiver, sampling mid-bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxBusy_ff <= 1'b0;
            rxCnt_ff <= 16'h0000;
            rxBit_ff <= 4'h0;
            rxSh_ff <= 8'h00;
            rxValid_ff <= 1'b0;
            rxData_ff <= 8'h00;
        end else begin
            if (rx.ready) begin
                rxValid_ff <= 1'b0;
            end
            if (!rxBusy_ff) begin
                if (!pinIn && !txBusy_ff) begin
                    rxBusy_ff <= 1'b1;
                    rxCnt_ff <= HALF;
                    rxBit_ff <= 4'h0;
                end
            end else if (rxCnt_ff != 16'h0000) begin
                rxCnt_ff <= rxCnt_ff - 16'h0001;
            end else begin
                rxCnt_ff <= FULL;
                rxBit_ff <= rxBit_ff + 4'h1;
                if (rxBit_ff == 4'h0 && pinIn) begin
                    rxBusy_ff <= 1'b0;
                end else if (rxBit_ff == sdbg_pkg::STOP_BIT_IDX) begin
                    rxBusy_ff <= 1'b0;
                    if (pinIn) begin
                        rxValid_ff <= 1'b1;
                        rxData_ff <= rxSh_ff;
                    end
                end else if (rxBit_ff != 4'h0) begin
                    rxSh_ff <= {pinIn, rxSh_ff[7:1]};
                end
            end
        end
    end

    // Transmitter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txBusy_ff <= 1'b0;
            txCnt_ff <= 16'h0000;
            txBit_ff <= 4'h0;
            txSh_ff <= 10'h3ff;
        end else if (!txBusy_ff) begin
            if (tx.valid && tx.ready) begin
                txBusy_ff <= 1'b1;
                txSh_ff <= {1'b1, tx.data, 1'b0};
                txCnt_ff <= FULL;
                txBit_ff <= 4'h0;
            end
        end else if (txCnt_ff != 16'h0000) begin
            txCnt_ff <= txCnt_ff - 16'h0001;
        end else begin
            txCnt_ff <= FULL;
            txSh_ff <= {1'b1, txSh_ff[9:1]};
            txBit_ff <= txBit_ff + 4'h1;
            if (txBit_ff == sdbg_pkg::STOP_BIT_IDX) begin
                txBusy_ff <= 1'b0;
            end
        end
    end

    property p_half_duplex;
        @(posedge clk_sys) disable iff (rst) pinOe |-> !rxBusy_ff;
    endproperty
    a_half_duplex: assert property (p_half_duplex)
        else $error("pin driven while receiving");
endmodule
`default_nettype wire

// ===== logic/sdbg_ctrl.sv
/*
  Single-pin debug controller top: debug mode state, breakpoint and
  reset-strap entry, control register actions, command decode, CRC.
  Assumes a core that runs one instruction per request and reports
  coreDone, and a program memory read port with one cycle of latency.
*/
`default_nettype none
// Contract
// - Debug mode stops fetch; core idles
// - Clock, peripherals run unless in stop
// - Entering debug leaves halt automatically
// - Debug mode keeps refreshing enabled watchdog
// - Breakpoint instruction enters debug mode
// - Pin low at reset end enters debug
// - Exit on flag clear, power-on, brown-out
// - 0EH returns program CRC, high byte first
// - 10H steps one instruction when allowed
// - 11H stuffs host opcode, executes one instruction
// - 12H executes host instruction, else discards byte
// - 81H reset-stop, 41H reset-go, 40H run
// - Control register: mode, breakpoint enable, reset
module sdbg_ctrl #(
    parameter int PM_BYTES = 4096,
    parameter int BIT_CYC = sdbg_pkg::BIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic debugSerialPinIn,
    output logic debugSerialPinOut,
    output logic debugSerialPinOe,
    input wire logic sysRstActive,
    input wire logic stopMode,
    input wire logic wdtEnable,
    input wire logic readProtect,
    input wire logic breakpointInstruction,
    input wire logic coreDone,
    input wire logic [2:0] opLen,
    input wire logic [7:0] pmRdData,
    input wire logic ctrlWrEn,
    input wire logic [7:0] ctrlWrData,
    output logic [7:0] ctrlRdData,
    output logic debugActiveFlag,
    output logic fetchHalt,
    output logic clkRun,
    output logic periphRun,
    output logic haltExit,
    output logic wdtRefresh,
    output logic deviceRstReq,
    output logic stepReq,
    output logic stuffReq,
    output logic execReq,
    output logic [39:0] instrBuf,
    output logic [2:0] instrLen,
    output logic [7:0] opProbe,
    output logic [$clog2(PM_BYTES)-1:0] pmAddr
);
    localparam int AW = $clog2(PM_BYTES) + 1;
    localparam logic [AW-1:0] PM_END = AW'(PM_BYTES);

    sdbg_byte_if #(.W(8)) rxIf ();
    sdbg_byte_if #(.W(8)) toFifo ();
    sdbg_byte_if #(.W(8)) fromFifo ();

    sdbg_pkg::sdbg_state_t state_ff;
    logic debug_ff;
    logic brkEn_ff;
    logic [2:0] rstCnt_ff;
    logic haltExit_ff;
    logic strapLow_ff;
    logic sysRstPrev_ff;
    logic running_ff;
    logic stepReq_ff;
    logic stuffReq_ff;
    logic execReq_ff;
    logic [39:0] instrBuf_ff;
    logic [2:0] idx_ff;
    logic [AW-1:0] addr_ff;
    logic pend_ff;
    logic [15:0] crc_ff;
    logic strapRel;
    logic brkHit;
    logic setEvt;
    logic cmdOk;
    logic nxt_debug;

    function automatic logic [15:0] crcByte(input logic [15:0] c,
                                            input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ sdbg_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    sdbg_serial #(.BIT_CYC(BIT_CYC)) uSerial (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(debugSerialPinIn),
        .pinOut(debugSerialPinOut),
        .pinOe(debugSerialPinOe),
        .rx(rxIf.src),
        .tx(fromFifo.snk)
    );

    sdbg_fifo2 #(.W(8), .DEPTH(2)) uTxBuf (
        .clk_sys(clk_sys),
        .rst(rst),
        .inIf(toFifo.snk),
        .outIf(fromFifo.src)
    );

    // Every received byte is taken at once
    assign rxIf.ready = 1'b1;
    assign toFifo.valid = (state_ff == sdbg_pkg::ST_SENDH) ||
                          (state_ff == sdbg_pkg::ST_SENDL);
    assign toFifo.data = (state_ff == sdbg_pkg::ST_SENDH) ? crc_ff[15:8]
                                                          : crc_ff[7:0];

    assign cmdOk = debug_ff && !readProtect;
    assign strapRel = sysRstPrev_ff && !sysRstActive && strapLow_ff;
    assign brkHit = breakpointInstruction && brkEn_ff;
    assign setEvt = brkHit || strapRel ||
        (ctrlWrEn && ctrlWrData[sdbg_pkg::CTRL_MODE_BIT]);

    // Entry sources win over a clear in the same cycle
    always_comb begin
        nxt_debug = debug_ff;
        if (ctrlWrEn) begin
            nxt_debug = ctrlWrData[sdbg_pkg::CTRL_MODE_BIT];
        end
        if (brkHit || strapRel) begin
            nxt_debug = 1'b1;
        end
    end

    // Debug mode flag; power-on and brown-out arrive on rst
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            debug_ff <= 1'b0;
            haltExit_ff <= 1'b0;
        end else begin
            debug_ff <= nxt_debug;
            haltExit_ff <= !debug_ff && nxt_debug;
        end
    end

    // Reset strap: last cycle of system reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strapLow_ff <= 1'b0;
            sysRstPrev_ff <= 1'b0;
        end else begin
            sysRstPrev_ff <= sysRstActive;
            if (sysRstActive) begin
                strapLow_ff <= !debugSerialPinIn;
            end
        end
    end

    // Breakpoint enable and whole-device reset request
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            brkEn_ff <= sdbg_pkg::CTRL_RESET_VAL[sdbg_pkg::CTRL_BRK_BIT];
            rstCnt_ff <= 3'h0;
        end else if (ctrlWrEn) begin
            brkEn_ff <= ctrlWrData[sdbg_pkg::CTRL_BRK_BIT];
            if (ctrlWrData[sdbg_pkg::CTRL_RST_BIT]) begin
                rstCnt_ff <= sdbg_pkg::RST_PULSE_CYC;
            end else if (rstCnt_ff != 3'h0) begin
                rstCnt_ff <= rstCnt_ff - 3'h1;
            end
        end else if (rstCnt_ff != 3'h0) begin
            rstCnt_ff <= rstCnt_ff - 3'h1;
        end
    end

    // Command sequencing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= sdbg_pkg::ST_IDLE;
            running_ff <= 1'b0;
            stepReq_ff <= 1'b0;
            stuffReq_ff <= 1'b0;
            execReq_ff <= 1'b0;
            instrBuf_ff <= 40'h00_0000_0000;
            idx_ff <= 3'h0;
        end else begin
            stepReq_ff <= 1'b0;
            stuffReq_ff <= 1'b0;
            execReq_ff <= 1'b0;
            unique case (state_ff)
                sdbg_pkg::ST_IDLE: begin
                    if (rxIf.valid) begin
                        if (rxIf.data == sdbg_pkg::CMD_CRC) begin
                            state_ff <= sdbg_pkg::ST_CRC;
                        end else if (rxIf.data == sdbg_pkg::CMD_STEP) begin
                            if (cmdOk) begin
                                stepReq_ff <= 1'b1;
                                running_ff <= 1'b1;
                                idx_ff <= 3'h0;
                                state_ff <= sdbg_pkg::ST_RUN;
                            end
                        end else if (rxIf.data == sdbg_pkg::CMD_STUFF) begin
                            if (cmdOk) begin
                                state_ff <= sdbg_pkg::ST_OPCODE;
                            end
                        end else if (rxIf.data == sdbg_pkg::CMD_EXEC) begin
                            idx_ff <= 3'h0;
                            state_ff <= cmdOk ? sdbg_pkg::ST_INSTR
                                              : sdbg_pkg::ST_DISCARD;
                        end
                    end
                end
                sdbg_pkg::ST_OPCODE: begin
                    if (rxIf.valid) begin
                        instrBuf_ff[7:0] <= rxIf.data;
                        idx_ff <= 3'h1;
                        stuffReq_ff <= 1'b1;
                        running_ff <= 1'b1;
                        state_ff <= sdbg_pkg::ST_RUN;
                    end
                end
                sdbg_pkg::ST_INSTR: begin
                    if (idx_ff != 3'h0 && (idx_ff >= opLen ||
                        idx_ff == sdbg_pkg::MAX_INSTR)) begin
                        execReq_ff <= 1'b1;
                        running_ff <= 1'b1;
                        state_ff <= sdbg_pkg::ST_RUN;
                    end else if (rxIf.valid) begin
                        instrBuf_ff[{idx_ff, 3'b000} +: 8] <= rxIf.data;
                        idx_ff <= idx_ff + 3'h1;
                    end
                end
                sdbg_pkg::ST_DISCARD: begin
                    if (rxIf.valid) begin
                        state_ff <= sdbg_pkg::ST_IDLE;
                    end
                end
                sdbg_pkg::ST_CRC: begin
                    if (addr_ff == PM_END && !pend_ff) begin
                        state_ff <= sdbg_pkg::ST_SENDH;
                    end
                end
                sdbg_pkg::ST_SENDH: begin
                    if (toFifo.ready) begin
                        state_ff <= sdbg_pkg::ST_SENDL;
                    end
                end
                sdbg_pkg::ST_SENDL: begin
                    if (toFifo.ready) begin
                        state_ff <= sdbg_pkg::ST_IDLE;
                    end
                end
                sdbg_pkg::ST_RUN: begin
                    if (coreDone) begin
                        running_ff <= 1'b0;
                        state_ff <= sdbg_pkg::ST_IDLE;
                    end
                end
                default: begin
                    running_ff <= 1'b0;
                    state_ff <= sdbg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Program memory CRC walk, one byte per cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_ff <= '0;
            pend_ff <= 1'b0;
            crc_ff <= sdbg_pkg::CRC_INIT;
        end else if (state_ff == sdbg_pkg::ST_IDLE && rxIf.valid &&
                     rxIf.data == sdbg_pkg::CMD_CRC) begin
            addr_ff <= '0;
            pend_ff <= 1'b0;
            crc_ff <= sdbg_pkg::CRC_INIT;
        end else if (state_ff == sdbg_pkg::ST_CRC) begin
            pend_ff <= addr_ff != PM_END;
            if (addr_ff != PM_END) begin
                addr_ff <= addr_ff + 1'b1;
            end
            if (pend_ff) begin
                crc_ff <= crcByte(crc_ff, pmRdData);
            end
        end
    end

    assign debugActiveFlag = debug_ff;
    assign ctrlRdData = {debug_ff, brkEn_ff, 5'h00,
                         rstCnt_ff != 3'h0};
    assign fetchHalt = debug_ff && !running_ff;
    assign clkRun = !stopMode;
    assign periphRun = !stopMode;
    assign haltExit = haltExit_ff;
    assign wdtRefresh = debug_ff && wdtEnable;
    assign deviceRstReq = rstCnt_ff != 3'h0;
    assign stepReq = stepReq_ff;
    assign stuffReq = stuffReq_ff;
    assign execReq = execReq_ff;
    assign instrBuf = instrBuf_ff;
    assign instrLen = idx_ff;
    assign opProbe = instrBuf_ff[7:0];
    assign pmAddr = addr_ff[AW-2:0];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_idle_core;
        debugActiveFlag && state_ff == sdbg_pkg::ST_IDLE |-> fetchHalt;
    endproperty
    a_idle_core: assert property (p_idle_core)
        else $error("core fetching while debug idle");

    property p_clk_run;
        !stopMode |-> clkRun && periphRun;
    endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("clock or peripherals stopped outside stop");

    property p_halt_exit;
        $rose(debugActiveFlag) |-> haltExit ##1 !haltExit;
    endproperty
    a_halt_exit: assert property (p_halt_exit)
        else $error("no halt exit pulse on debug entry");

    property p_wdt;
        debugActiveFlag && wdtEnable |-> wdtRefresh;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog not refreshed in debug");

    property p_brk;
        breakpointInstruction && ctrlRdData[sdbg_pkg::CTRL_BRK_BIT]
            |=> debugActiveFlag;
    endproperty
    a_brk: assert property (p_brk)
        else $error("breakpoint did not enter debug");

    sequence s_strap;
        sysRstActive && !debugSerialPinIn ##1 !sysRstActive;
    endsequence
    property p_strap;
        s_strap |=> debugActiveFlag;
    endproperty
    a_strap: assert property (p_strap)
        else $error("reset strap did not enter debug");

    property p_exit;
        ctrlWrEn && !ctrlWrData[sdbg_pkg::CTRL_MODE_BIT] && !setEvt
            |=> !debugActiveFlag;
    endproperty
    a_exit: assert property (p_exit)
        else $error("debug flag clear ignored");

    sequence s_crc_high;
        state_ff == sdbg_pkg::ST_SENDH && toFifo.ready;
    endsequence
    property p_crc_order;
        s_crc_high |=> state_ff == sdbg_pkg::ST_SENDL &&
            toFifo.valid && toFifo.data == $past(crc_ff[7:0]);
    endproperty
    a_crc_order: assert property (p_crc_order)
        else $error("CRC low byte not after high byte");

    property p_step_block;
        state_ff == sdbg_pkg::ST_IDLE && rxIf.valid &&
            rxIf.data == sdbg_pkg::CMD_STEP && !cmdOk
            |=> !stepReq && state_ff == sdbg_pkg::ST_IDLE;
    endproperty
    a_step_block: assert property (p_step_block)
        else $error("step taken while not allowed");

    property p_stuff;
        state_ff == sdbg_pkg::ST_OPCODE && rxIf.valid
            |=> stuffReq && opProbe == $past(rxIf.data);
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("stuffed opcode not issued");

    sequence s_discard;
        state_ff == sdbg_pkg::ST_IDLE && rxIf.valid &&
            rxIf.data == sdbg_pkg::CMD_EXEC && !cmdOk;
    endsequence
    property p_discard;
        s_discard |=> state_ff == sdbg_pkg::ST_DISCARD && !execReq;
    endproperty
    a_discard: assert property (p_discard)
        else $error("blocked execute not discarding");

    property p_rst_stop;
        ctrlWrEn && ctrlWrData == sdbg_pkg::CTRL_RST_STOP
            |=> debugActiveFlag && deviceRstReq [*4] ##1 !deviceRstReq;
    endproperty
    a_rst_stop: assert property (p_rst_stop)
        else $error("reset-stop write misbehaved");

    property p_readback;
        ctrlRdData[sdbg_pkg::CTRL_MODE_BIT] == debugActiveFlag;
    endproperty
    a_readback: assert property (p_readback)
        else $error("mode flag readback wrong");
endmodule
`default_nettype wire

// ===== verification/sdbg_host_model.sv
/* Debug host model: sends and receives pin frames.
   Assumes the bench resolves the pulled-up wire. */
`default_nettype none
module sdbg_host_model #(parameter int BIT_CYC = 16) (
    input wire logic clk_sys,
    input wire logic pin,
    output logic hostOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial hostOut = 1'b1;
    task automatic hold(input logic v);
        hostOut <= v;
    endtask
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10 * BIT_CYC; i++) begin
            @(posedge clk_sys);
            hostOut <= f[i / BIT_CYC];
        end
    endtask
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        while (pin === 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            b[i] = pin;
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// ===== verification/single_pin_debug_controller_tb_top.sv
/* Bench for the debug controller with a host model on the pin.
   Assumes sim values BIT_CYC 16 and PM_BYTES 8. */
`default_nettype none
module single_pin_debug_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, stopMode = 0, bp = 0, coreDone = 0;
    logic wrEn = 0, pOut, pOe, hOut, pin;
    logic [7:0] wrD = 0, pmD = 0, rd, b1, b0, oProbe;
    logic flag, fHalt, cRun, pRun, hExit, wdtR, rReq, sReq, uReq, xReq;
    logic sra = 0, rp = 0;
    logic [39:0] iBuf;
    logic [2:0] pmA, iLen;
    int errTotal = 0, nChecks = 0, cyc = 0;
    int nStep = 0, nStuff = 0, nExec = 0;
    assign pin = pOe ? pOut : hOut;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pmD <= 8'h5a ^ {5'h00, pmA};
    // Request pulses last one cycle, so they are counted here
    always @(posedge clk_sys) begin
        if (sReq === 1'b1) nStep++;
        if (uReq === 1'b1) nStuff++;
        if (xReq === 1'b1) nExec++;
    end
    sdbg_ctrl #(.PM_BYTES(8), .BIT_CYC(16)) u_dut (.clk_sys(clk_sys),
        .rst(rst), .debugSerialPinIn(pin), .debugSerialPinOut(pOut),
        .debugSerialPinOe(pOe), .sysRstActive(sra), .stopMode(stopMode),
        .wdtEnable(1'b1), .readProtect(rp), .breakpointInstruction(bp),
        .coreDone(coreDone), .opLen(3'h1), .pmRdData(pmD),
        .ctrlWrEn(wrEn), .ctrlWrData(wrD), .ctrlRdData(rd),
        .debugActiveFlag(flag), .fetchHalt(fHalt), .clkRun(cRun),
        .periphRun(pRun), .haltExit(hExit), .wdtRefresh(wdtR),
        .deviceRstReq(rReq), .stepReq(sReq), .stuffReq(uReq),
        .execReq(xReq), .instrBuf(iBuf), .instrLen(iLen), .opProbe(oProbe),
        .pmAddr(pmA));
    sdbg_host_model #(.BIT_CYC(16)) u_host (.clk_sys(clk_sys), .pin(pin),
        .hostOut(hOut));
    task automatic chk(input logic ok, input string m);
        nChecks++;
        if (!ok) begin
            errTotal++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wrCtrl(input logic [7:0] d);
        @(posedge clk_sys);
        wrEn <= 1'b1;
        wrD <= d;
        @(posedge clk_sys);
        wrEn <= 1'b0;
        #1;
    endtask
    task automatic waitReq(input int got, input int exp, input logic [7:0] op);
        #1;
        chk(got == exp, "no request");
        chk(iBuf[7:0] === op, "instruction byte");
        chk(fHalt === 1'b0, "fetch not released");
        @(posedge clk_sys);
        coreDone <= 1'b1;
        @(posedge clk_sys);
        coreDone <= 1'b0;
    endtask
    function automatic logic [15:0] crcExp();
        logic [15:0] c;
        c = sdbg_pkg::CRC_INIT;
        for (int a = 0; a < 8; a++) begin
            c = c ^ {8'h5a ^ 8'(a), 8'h00};
            for (int k = 0; k < 8; k++) begin
                c = c[15] ? (c << 1) ^ sdbg_pkg::CRC_POLY : c << 1;
            end
        end
        return c;
    endfunction
    task automatic t_basic();
        chk(flag === 1'b0 && rd === 8'h00, "reset state");
        @(posedge clk_sys);
        stopMode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk(cRun === 1'b0 && pRun === 1'b0, "stop gates");
        @(posedge clk_sys);
        stopMode <= 1'b0;
        wrCtrl(sdbg_pkg::CTRL_RUN);
        chk(flag === 1'b0 && rd[6] === 1'b1, "break enable");
        @(posedge clk_sys);
        bp <= 1'b1;
        @(posedge clk_sys);
        bp <= 1'b0;
        #1;
        chk(flag === 1'b1 && hExit === 1'b1, "break entry");
        chk(fHalt === 1'b1 && wdtR === 1'b1, "halt, refresh");
        chk(rd[7] === 1'b1 && cRun === 1'b1, "flag reads");
        $display("basic test done");
    endtask
    task automatic t_cmds();
        u_host.send(sdbg_pkg::CMD_STEP);
        waitReq(nStep, 1, 8'h00);
        u_host.send(sdbg_pkg::CMD_STUFF);
        u_host.send(8'ha5);
        waitReq(nStuff, 1, 8'ha5);
        chk(oProbe === 8'ha5, "stuff probe");
        u_host.send(sdbg_pkg::CMD_EXEC);
        u_host.send(8'h3c);
        waitReq(nExec, 1, 8'h3c);
        chk(iLen === 3'h1 && oProbe === 8'h3c, "exec length");
        u_host.send(sdbg_pkg::CMD_CRC);
        u_host.recv(b1);
        u_host.recv(b0);
        chk({b1, b0} === crcExp(), "crc");
        repeat (16) @(posedge clk_sys);
        rp <= 1'b1;
        u_host.send(sdbg_pkg::CMD_STEP);
        #1;
        chk(nStep == 1 && fHalt === 1'b1, "step blocked");
        u_host.send(sdbg_pkg::CMD_EXEC);
        rp <= 1'b0;
        u_host.send(sdbg_pkg::CMD_STEP);
        #1;
        chk(nStep == 1 && fHalt === 1'b1, "byte discarded");
        $display("command test done");
    endtask
    task automatic t_ctrl();
        wrCtrl(8'h00);
        chk(flag === 1'b0, "clear exits");
        wrCtrl(sdbg_pkg::CTRL_RST_STOP);
        chk(flag === 1'b1 && rReq === 1'b1, "reset stop");
        repeat (3) @(posedge clk_sys);
        #1;
        chk(rReq === 1'b1, "reset held");
        @(posedge clk_sys);
        #1;
        chk(rReq === 1'b0, "reset ends");
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(flag === 1'b0, "reset exits");
        @(posedge clk_sys);
        sra <= 1'b1;
        u_host.hold(1'b0);
        @(posedge clk_sys);
        sra <= 1'b0;
        u_host.hold(1'b1);
        @(posedge clk_sys);
        #1;
        chk(flag === 1'b1, "strap entry");
        wrCtrl(sdbg_pkg::CTRL_RUN);
        chk(flag === 1'b0, "run resumes");
        $display("control test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            errTotal++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        t_basic();
        t_cmds();
        t_ctrl();
        wrap_up();
    end
endmodule
`default_nettype wire
